// ==== logic/dmahrd_pkg.sv ====
package dmahrd_pkg;

  // ----------------------------------------
  // Port widths
  // ----------------------------------------
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned CHAN_N     = 4;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned MODE_W     = 6;

  // ----------------------------------------
  // Command-space address codes (A3..A0)
  // ----------------------------------------
  localparam logic [3:0] ADR_STATUS_CMD   = 4'h8;
  localparam logic [3:0] ADR_REQUEST      = 4'h9;
  localparam logic [3:0] ADR_SINGLE_MASK  = 4'hA;
  localparam logic [3:0] ADR_MODE         = 4'hB;
  localparam logic [3:0] ADR_PTR_CLEAR    = 4'hC;
  localparam logic [3:0] ADR_TEMP_SOFTRST = 4'hD;
  localparam logic [3:0] ADR_UNMASK_ALL   = 4'hE;
  localparam logic [3:0] ADR_ALL_MASK     = 4'hF;

  // ----------------------------------------
  // Address field positions
  // ----------------------------------------
  localparam int unsigned ADR_SPACE_BIT   = 3;
  localparam int unsigned ADR_COUNT_BIT   = 0;
  localparam int unsigned ADR_CHAN_LSB    = 1;

  // ----------------------------------------
  // Data field positions
  // ----------------------------------------
  localparam int unsigned DAT_CHAN_LSB    = 0;
  localparam int unsigned DAT_SET_BIT     = 2;
  localparam int unsigned DAT_MODE_LSB    = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_SETUP    = 8'h00;
  localparam logic [7:0]  RST_STATUS   = 8'h00;
  localparam logic [3:0]  RST_REQUEST  = 4'h0;
  localparam logic [7:0]  RST_TEMP     = 8'h00;
  localparam logic [3:0]  RST_MASK     = 4'hF;
  localparam logic [5:0]  RST_MODE     = 6'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [7:0]  RD_IDLE      = 8'h00;

  // ----------------------------------------
  // Word store layout: entry = {chan, isCount}
  // ----------------------------------------
  localparam int unsigned WSEL_W       = 3;

  // Controller activity
  typedef enum logic [1:0] {
    DMAHRD_IDLE   = 2'b01,
    DMAHRD_ACTIVE = 2'b10
  } dmahrd_state_e;

endpackage

// ==== logic/dmahrd_word_store.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Base and current word store, one entry per channel register
// ----------------------------------------
module dmahrd_word_store (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              arst_n,
  // Byte write port
  input  wire logic                              wrEn,
  input  wire logic [dmahrd_pkg::WSEL_W-1:0]     wrSel,
  input  wire logic                              wrHigh,
  input  wire logic [dmahrd_pkg::DATA_W-1:0]     wrData,
  // Byte read port
  input  wire logic [dmahrd_pkg::WSEL_W-1:0]     rdSel,
  input  wire logic                              rdHigh,
  output logic      [dmahrd_pkg::DATA_W-1:0]     rdData_q,
  // Base copies for the transfer engine
  output logic      [dmahrd_pkg::WORD_W-1:0]     baseWord [8]
);
  import dmahrd_pkg::*;

  logic [WORD_W-1:0] curWord_q [8];

  // One entry per register; base and current written together
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gEntry
      logic [WORD_W-1:0] base_q;
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          base_q        <= RST_WORD;
          curWord_q[g]  <= RST_WORD;
        end else if (wrEn && (wrSel == WSEL_W'(g))) begin
          if (wrHigh) begin
            base_q[15:8]       <= wrData;
            curWord_q[g][15:8] <= wrData;
          end else begin
            base_q[7:0]        <= wrData;
            curWord_q[g][7:0]  <= wrData;
          end
        end
      end
      assign baseWord[g] = base_q;
    end
  endgenerate

  // Only the current copy is readable; base stays hidden
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= RD_IDLE;
    end else begin
      rdData_q <= rdHigh ? curWord_q[rdSel][15:8] : curWord_q[rdSel][7:0];
    end
  end

endmodule

// ==== logic/dmahrd_register_decoder.sv ====
`timescale 1ns/1ps

module dmahrd_register_decoder (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              arst_n,
  // Host bus pins
  input  wire logic                              chip_select_n,
  input  wire logic                              io_read_strobe_n,
  input  wire logic                              io_write_strobe_n,
  input  wire logic [dmahrd_pkg::ADDR_W-1:0]     host_addr,
  input  wire logic [dmahrd_pkg::DATA_W-1:0]     data_in,
  output logic      [dmahrd_pkg::DATA_W-1:0]     data_out,
  output logic                                   data_oe_n,
  // Arbitration pins
  input  wire logic                              hold_acknowledge,
  input  wire logic [dmahrd_pkg::CHAN_N-1:0]     channel_service_request,
  // State from the transfer engine
  input  wire logic [dmahrd_pkg::CHAN_N-1:0]     terminal_count_evt,
  input  wire logic [dmahrd_pkg::DATA_W-1:0]     temp_load_data,
  input  wire logic                              temp_load_en,
  // Programmed state to the transfer engine
  output logic      [dmahrd_pkg::DATA_W-1:0]     setup_q,
  output logic      [dmahrd_pkg::CHAN_N-1:0]     request_q,
  output logic      [dmahrd_pkg::CHAN_N-1:0]     mask_q,
  output logic      [dmahrd_pkg::MODE_W*4-1:0]   mode_q,
  output logic                                   soft_reset_q,
  output logic                                   byte_ptr_q,
  output logic                                   idle_q
);
  import dmahrd_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages; strobes count once stages two and three agree
  logic [2:0] csSync_q;
  logic [2:0] rdSync_q;
  logic [2:0] wrSync_q;
  logic [2:0] hldaSync_q;
  logic       csLvl_q;
  logic       rdLvl_q;
  logic       wrLvl_q;
  logic       hldaLvl_q;
  logic       rdLvlDly_q;
  logic       wrLvlDly_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      csSync_q   <= 3'b111;
      rdSync_q   <= 3'b111;
      wrSync_q   <= 3'b111;
      hldaSync_q <= 3'b000;
    end else begin
      csSync_q   <= {csSync_q[1:0], chip_select_n};
      rdSync_q   <= {rdSync_q[1:0], io_read_strobe_n};
      wrSync_q   <= {wrSync_q[1:0], io_write_strobe_n};
      hldaSync_q <= {hldaSync_q[1:0], hold_acknowledge};
    end
  end

  // Filtered levels change only when the last two stages agree
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      csLvl_q   <= 1'b1;
      rdLvl_q   <= 1'b1;
      wrLvl_q   <= 1'b1;
      hldaLvl_q <= 1'b0;
    end else begin
      if (csSync_q[1] == csSync_q[2]) csLvl_q <= csSync_q[2];
      if (rdSync_q[1] == rdSync_q[2]) rdLvl_q <= rdSync_q[2];
      if (wrSync_q[1] == wrSync_q[2]) wrLvl_q <= wrSync_q[2];
      if (hldaSync_q[1] == hldaSync_q[2]) hldaLvl_q <= hldaSync_q[2];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdLvlDly_q <= 1'b1;
      wrLvlDly_q <= 1'b1;
    end else begin
      rdLvlDly_q <= rdLvl_q;
      wrLvlDly_q <= wrLvl_q;
    end
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  // Address and data are stable by the strobe edge, so sampling them
  // directly beside the filtered strobe is safe for a quasi-static bus.
  logic       hostOwn;
  logic       wrPulse;
  logic       rdPulse;
  logic       rdActive;
  logic       chanSpace;
  logic       chanWr;
  logic       chanRd;
  logic [3:0] cmdWr;

  assign hostOwn   = !csLvl_q && !hldaLvl_q;
  // Write acts on the trailing edge, when data is surely settled
  assign wrPulse   = hostOwn && !wrLvlDly_q && wrLvl_q;
  assign rdPulse   = hostOwn && !rdLvlDly_q && rdLvl_q;
  assign rdActive  = hostOwn && !rdLvl_q;
  assign chanSpace = !host_addr[ADR_SPACE_BIT];
  assign chanWr    = wrPulse && chanSpace;
  assign chanRd    = rdPulse && chanSpace;
  assign cmdWr     = host_addr;

  // ----------------------------------------
  // Soft reset and byte pointer
  // ----------------------------------------
  logic softRst;
  assign softRst = wrPulse && (cmdWr == ADR_TEMP_SOFTRST);

  // Pulse out so the transfer engine can drop to idle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= softRst;
    end
  end

  // Pointer toggles after every channel byte access
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_ptr_q <= 1'b0;
    end else if (softRst) begin
      byte_ptr_q <= 1'b0;
    end else if (wrPulse && (cmdWr == ADR_PTR_CLEAR)) begin
      byte_ptr_q <= 1'b0;
    end else if (chanWr || chanRd) begin
      byte_ptr_q <= ~byte_ptr_q;
    end
  end

  // ----------------------------------------
  // Channel word store
  // ----------------------------------------
  logic [DATA_W-1:0] wordRd;
  logic [WORD_W-1:0] baseWord [8];

  // Each byte lands as soon as written; a live unmasked channel may start
  // on a half-written value, which is why software masks it first.
  dmahrd_word_store uStore (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .wrEn     (chanWr),
    .wrSel    (host_addr[2:0]),
    .wrHigh   (byte_ptr_q),
    .wrData   (data_in),
    .rdSel    (host_addr[2:0]),
    .rdHigh   (byte_ptr_q),
    .rdData_q (wordRd),
    .baseWord (baseWord)
  );

  // ----------------------------------------
  // Command and request registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_q <= RST_SETUP;
    end else if (softRst) begin
      setup_q <= RST_SETUP;
    end else if (wrPulse && (cmdWr == ADR_STATUS_CMD)) begin
      setup_q <= data_in;
    end
  end

  // Request bit addressed by data; terminal count clears, write wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      request_q <= RST_REQUEST;
    end else if (softRst) begin
      request_q <= RST_REQUEST;
    end else begin
      for (int i = 0; i < CHAN_N; i++) begin
        if (wrPulse && (cmdWr == ADR_REQUEST) && (data_in[1:0] == 2'(i))) begin
          request_q[i] <= data_in[DAT_SET_BIT];
        end else if (terminal_count_evt[i]) begin
          request_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Mask register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= RST_MASK;
    end else if (softRst) begin
      mask_q <= RST_MASK;
    end else if (wrPulse && (cmdWr == ADR_UNMASK_ALL)) begin
      mask_q <= 4'h0;
    end else if (wrPulse && (cmdWr == ADR_ALL_MASK)) begin
      mask_q <= data_in[3:0];
    end else if (wrPulse && (cmdWr == ADR_SINGLE_MASK)) begin
      // Only the named bit moves, and
      mask_q[data_in[1:0]] <= data_in[DAT_SET_BIT];
    end
  end

  // ----------------------------------------
  // Mode registers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHAN_N; g++) begin : gMode
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          mode_q[g*MODE_W +: MODE_W] <= RST_MODE;
        end else if (wrPulse && (cmdWr == ADR_MODE) && (data_in[1:0] == 2'(g))) begin
          // Low two data bits name the channel, and
          mode_q[g*MODE_W +: MODE_W] <= data_in[7:DAT_MODE_LSB];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Status and temporary registers
  // ----------------------------------------
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] temp_q;
  logic [CHAN_N-1:0] dreqSync1_q;
  logic [CHAN_N-1:0] dreqSync2_q;
  logic [CHAN_N-1:0] dreqSync3_q;
  logic              statusRd;

  assign statusRd = rdPulse && (cmdWr == ADR_STATUS_CMD);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dreqSync1_q <= 4'h0;
      dreqSync2_q <= 4'h0;
      dreqSync3_q <= 4'h0;
    end else begin
      dreqSync1_q <= channel_service_request;
      dreqSync2_q <= dreqSync1_q;
      dreqSync3_q <= dreqSync2_q;
    end
  end

  // Terminal count flags clear on read, but a new count wins the clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= RST_STATUS;
    end else if (softRst) begin
      status_q <= RST_STATUS;
    end else begin
      // Request bits move only once the last two stages agree
      status_q[7:4] <= (dreqSync2_q & dreqSync3_q) | (status_q[7:4] & (dreqSync2_q | dreqSync3_q));
      status_q[3:0] <= (statusRd ? 4'h0 : status_q[3:0]) | terminal_count_evt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_q <= RST_TEMP;
    end else if (softRst) begin
      temp_q <= RST_TEMP;
    end else if (temp_load_en) begin
      temp_q <= temp_load_data;
    end
  end

  // ----------------------------------------
  // Activity state
  // ----------------------------------------
  dmahrd_state_e state_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= DMAHRD_IDLE;
    end else if (softRst) begin
      state_q <= DMAHRD_IDLE;
    end else begin
      case (state_q)
        DMAHRD_IDLE:   if (hldaLvl_q) state_q <= DMAHRD_ACTIVE;
        DMAHRD_ACTIVE: if (!hldaLvl_q) state_q <= DMAHRD_IDLE;
        default:       state_q <= DMAHRD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 1'b1;
    end else begin
      idle_q <= (state_q == DMAHRD_IDLE);
    end
  end

  // ----------------------------------------
  // Read data drive
  // ----------------------------------------
  // Illegal read codes return zero rather than stale data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out  <= RD_IDLE;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !rdActive;
      if (chanSpace) begin
        data_out <= wordRd;
      end else if (cmdWr == ADR_STATUS_CMD) begin
        data_out <= status_q;
      end else if (cmdWr == ADR_TEMP_SOFTRST) begin
        data_out <= temp_q;
      end else begin
        data_out <= RD_IDLE;
      end
    end
  end

endmodule

// ==== testbench/dmahrd_register_decoder_chk.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Decoder port checker
// ----------------------------------------
module dmahrd_register_decoder_chk
  import dmahrd_pkg::*;
(
  // Clock and reset
  input wire logic                           sys_clk,
  input wire logic                           arst_n,
  // Host pins
  input wire logic                           io_read_strobe_n,
  input wire logic                           io_write_strobe_n,
  input wire logic                           hold_acknowledge,
  input wire logic                           data_oe_n,
  // Programmed state
  input wire logic [dmahrd_pkg::DATA_W-1:0]  setup_q,
  input wire logic [dmahrd_pkg::CHAN_N-1:0]  mask_q,
  input wire logic                           byte_ptr_q,
  input wire logic                           soft_reset_q,
  input wire logic                           idle_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Quiet spans; eight cycles outlast the pin synchronisers
  sequence s_rd_quiet;
    io_read_strobe_n [*8];
  endsequence
  sequence s_ack_held;
    hold_acknowledge [*8];
  endsequence
  // Seven samples cover the pin filter, the state step and the idle flop
  sequence s_ack_on;
    hold_acknowledge [*7];
  endsequence
  sequence s_ack_off;
    !hold_acknowledge [*7];
  endsequence
  sequence s_cleared;
    mask_q == RST_MASK && setup_q == RST_SETUP && !byte_ptr_q;
  endsequence

  a_oe_release: assert property (s_rd_quiet |-> data_oe_n)
    else $error("bus driven without a read");
  a_oe_cause: assert property ($fell(data_oe_n) |-> !io_read_strobe_n)
    else $error("bus drive began without read strobe");
  a_held_frozen: assert property (s_ack_held |-> $stable({setup_q, mask_q, byte_ptr_q}))
    else $error("state moved while hold acknowledge high");
  a_setup_trail: assert property ($changed(setup_q) |-> io_write_strobe_n)
    else $error("setup changed before write trailing edge");
  a_ptr_trail: assert property ($changed(byte_ptr_q) |-> io_write_strobe_n && io_read_strobe_n)
    else $error("pointer moved inside a strobe");
  a_mask_trail: assert property ($changed(mask_q) |-> io_write_strobe_n)
    else $error("mask changed before write trailing edge");
  a_clear_values: assert property (soft_reset_q |-> ##[0:2] s_cleared)
    else $error("soft reset left state behind");
  a_pulse_once: assert property (soft_reset_q |=> !soft_reset_q)
    else $error("soft reset pulse too long");
  a_idle_busy: assert property (s_ack_on |-> !idle_q)
    else $error("idle while acknowledged");
  a_idle_free: assert property (s_ack_off |-> idle_q)
    else $error("not idle without acknowledge");
endmodule

bind dmahrd_register_decoder dmahrd_register_decoder_chk dmahrd_register_decoder_chk_inst (
  .sys_clk(sys_clk), .arst_n(arst_n), .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n), .hold_acknowledge(hold_acknowledge), .data_oe_n(data_oe_n),
  .setup_q(setup_q), .mask_q(mask_q), .byte_ptr_q(byte_ptr_q), .soft_reset_q(soft_reset_q), .idle_q(idle_q)
);

// ==== testbench/dmahrd_host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Host processor on the byte-wide bus
// ----------------------------------------
module dmahrd_host_model (
  // Clock
  input wire logic                           sysClk,
  // Bus towards the device
  output logic                               csN,
  output logic                               rdN,
  output logic                               wrN,
  output logic [dmahrd_pkg::ADDR_W-1:0]      addr,
  output logic [dmahrd_pkg::DATA_W-1:0]      dataIn,
  // Bus from the device
  input wire logic [dmahrd_pkg::DATA_W-1:0]  dataOut,
  input wire logic                           oeN
);
  int gapCyc = 8;  // Hold past trailing edge; a slow host raises it

  // Bus parked and deselected
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    addr = 4'h0;
    dataIn = 8'h00;
  end

  // Select and present address, only legal codes are issued
  task automatic start(input logic [3:0] a, input logic [7:0] d);
    @(posedge sysClk);
    #5;
    csN = 1'b0;
    addr = a;
    dataIn = d;
  endtask

  // Hold past the trailing edge, then let go; released lines flip
  task automatic finish();
    repeat (gapCyc) @(posedge sysClk);
    #5;
    csN = 1'b1;
    addr = ~addr;
    dataIn = ~dataIn;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    start(a, d);
    wrN = 1'b0;
    repeat (4) @(posedge sysClk);
    #5;
    wrN = 1'b1;
    finish();
  endtask

  // Strobe held until the device drives; outputs looked at once settled
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    start(a, ~dataIn);
    rdN = 1'b0;
    n = 0;
    while (oeN !== 1'b0 && n < 12) begin
      @(posedge sysClk);
      #5;
      n++;
    end
    @(posedge sysClk);
    #5;
    d = dataOut;
    rdN = 1'b1;
    finish();
  endtask
endmodule

// ==== testbench/dmahrd_register_decoder_tb.sv ====
`timescale 1ns/1ps

module dmahrd_register_decoder_tb;
  import dmahrd_pkg::*;

  typedef struct packed {
    logic [3:0]  a;
    logic [7:0]  d;
    logic [1:0]  k;
    logic [23:0] e;
  } dmahrd_row_s;

  logic        sysClk = 1'b0;
  logic        arstN = 1'b0;
  logic        csN, rdN, wrN, oeN, holdAck, tempEn, bytePtrQ, idleQ;
  logic [3:0]  hostAddr, chanReq, tcEvt, requestQ, maskQ;
  logic [7:0]  dataIn, dataOut, tempData, setupQ;
  logic [23:0] modeQ;
  int          badCount = 0;
  int          cmpCount = 0;

  // Row kinds: 0 setup, 1 request, 2 mask, 3 mode
  dmahrd_row_s rows [10] = '{
    '{4'h8, 8'hA5, 2'd0, 24'h00_00A5},
    '{4'h9, 8'h06, 2'd1, 24'h00_0004},
    '{4'h9, 8'h02, 2'd1, 24'h00_0000},
    '{4'hE, 8'h5A, 2'd2, 24'h00_0000},
    '{4'hF, 8'h0B, 2'd2, 24'h00_000B},
    '{4'hA, 8'h06, 2'd2, 24'h00_000F},
    '{4'hA, 8'h02, 2'd2, 24'h00_000B},
    '{4'hA, 8'h01, 2'd2, 24'h00_0009},
    '{4'hB, 8'hAE, 2'd3, {6'h00, 6'h2B, 12'h000}},
    '{4'hB, 8'h57, 2'd3, {6'h15, 6'h2B, 12'h000}}
  };

  always #50 sysClk = ~sysClk;

  dmahrd_host_model dmahrd_host_model_inst (
    .sysClk(sysClk), .csN(csN), .rdN(rdN), .wrN(wrN), .addr(hostAddr),
    .dataIn(dataIn), .dataOut(dataOut), .oeN(oeN)
  );

  dmahrd_register_decoder dmahrd_register_decoder_inst (
    .sys_clk(sysClk), .arst_n(arstN), .chip_select_n(csN), .io_read_strobe_n(rdN),
    .io_write_strobe_n(wrN), .host_addr(hostAddr), .data_in(dataIn), .data_out(dataOut),
    .data_oe_n(oeN), .hold_acknowledge(holdAck), .channel_service_request(chanReq),
    .terminal_count_evt(tcEvt), .temp_load_data(tempData), .temp_load_en(tempEn),
    .setup_q(setupQ), .request_q(requestQ), .mask_q(maskQ), .mode_q(modeQ),
    .soft_reset_q(), .byte_ptr_q(bytePtrQ), .idle_q(idleQ)
  );

  function automatic logic [23:0] pick(input logic [1:0] k);
    case (k)
      2'd0: return {16'h0000, setupQ};
      2'd1: return {20'h0_0000, requestQ};
      2'd2: return {20'h0_0000, maskQ};
      default: return modeQ;
    endcase
  endfunction

  task automatic chk_reg(input logic [23:0] got, input logic [23:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    dmahrd_host_model_inst.wr(a, d);
  endtask

  task automatic r(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] got;
    dmahrd_host_model_inst.rd(a, got);
    chk_rd(got, e);
  endtask

  task automatic testDone();
    $display("compared %0d mismatched %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 500 cycles the run needs
  initial begin
    #(2_000_000);
    badCount++;
    testDone();
  end

  // Main sequence
  initial begin
    holdAck = 1'b0;
    chanReq = 4'h5;
    tcEvt = 4'h0;
    tempData = 8'h00;
    tempEn = 1'b0;
    repeat (10) @(posedge sysClk);
    #5;
    arstN = 1'b1;
    chk_reg({12'h000, setupQ, maskQ}, {12'h000, RST_SETUP, RST_MASK});
    chk_reg({21'h00_0000, bytePtrQ, idleQ, oeN}, 24'h00_0003);
    foreach (rows[i]) begin
      w(rows[i].a, rows[i].d);
      chk_reg(pick(rows[i].k), rows[i].e);
    end
    // Byte pointer across channel registers, typical set-up order
    w(4'hC, 8'hFF);
    chk_reg(24'(bytePtrQ), 24'h00_0000);
    w(4'h4, 8'h37);
    chk_reg(24'(bytePtrQ), 24'h00_0001);
    w(4'h4, 8'h82);
    w(4'h5, 8'h17);
    w(4'h5, 8'h95);
    w(4'h6, 8'h11);
    w(4'hC, 8'h00);
    chk_reg(24'(bytePtrQ), 24'h00_0000);
    r(4'h4, 8'h37);
    r(4'h4, 8'h82);
    r(4'h5, 8'h17);
    r(4'h5, 8'h95);
    r(4'h6, 8'h11);
    r(4'h6, 8'h00);
    // Status with a terminal count, then the temporary register
    @(posedge sysClk);
    #5;
    tcEvt = 4'h2;
    tempData = 8'h3C;
    tempEn = 1'b1;
    @(posedge sysClk);
    #5;
    tcEvt = 4'h0;
    tempEn = 1'b0;
    r(4'h8, 8'h52);
    r(4'h8, 8'h50);
    r(4'hD, 8'h3C);
    // A read at the soft reset code must leave the temporary register alone
    r(4'hD, 8'h3C);
    // Access while acknowledged is refused
    holdAck = 1'b1;
    repeat (4) @(posedge sysClk);
    w(4'h8, 8'h77);
    chk_reg({16'h0000, setupQ}, 24'h00_00A5);
    chk_reg(24'(idleQ), 24'h00_0000);
    holdAck = 1'b0;
    // Soft reset from a slow host with pointer and request set
    dmahrd_host_model_inst.gapCyc = 14;
    w(4'h9, 8'h07);
    w(4'h0, 8'h01);
    w(4'hD, 8'h5A);
    chk_reg({setupQ, requestQ, maskQ, 7'h00, bytePtrQ}, {RST_SETUP, RST_REQUEST, RST_MASK, 8'h00});
    r(4'hD, RST_TEMP);
    r(4'h8, 8'h50);
    testDone();
  end
endmodule
